//--- ufc_top.sv
// uart frame format and control: apb registers, flow control, tx and rx
// assumes an apb master on clk; rxd and cts_n arrive from another domain
//
// Behaviour
// - writing one to abort_unit stops any transfer and returns the unit to idle
// - abort_unit is write-one only, reads zero, and is zero after any wake-up
// - handshake_enable one uses rts and cts; zero ignores both pins
// - nine_bit_enable zero gives 8-bit characters, one adds a ninth bit
// - without parity the stored ninth_bit_value is sent as the ninth bit
// - with parity, ninth_bit_value zero selects even, one selects odd parity
// - check_bit_enable turns parity generation and checking on or off together
// - stop_count_select zero sends one stop bit, one sends two
// - end_bit_level sets stop bit level sent and expected; reset value one
// - begin_bit_level sets start level; idle is the opposite level
// - all control fields reset to zero except the stop level
// - a stop bit at the wrong level raises a framing error
// - a failed parity check raises a parity error
`timescale 1ns/1ps
module ufc_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    input  wire logic        cts_n,
    output logic             rts_n,
    output logic             irq
);

    // ***************************************************************
    // declarations
    // ***************************************************************
    ufc_pkg::ufc_cfg_s ctrl_reg;
    ufc_pkg::ufc_evt_s stat_reg;
    ufc_pkg::ufc_evt_s stat_next;
    ufc_pkg::ufc_evt_s mask_reg;
    ufc_pkg::ufc_evt_s evt_set;
    logic [15:0] baud_reg;
    logic [15:0] div_reg;
    logic [7:0]  tx_hold_reg;
    logic        tx_full_reg;
    logic        rx_full_reg;
    logic        rts_n_reg;
    logic [31:0] prdata_reg;
    logic [1:0]  s1_reg;
    logic [1:0]  s2_reg;
    logic [1:0]  s3_reg;
    logic [1:0]  pin_reg;
    logic        tx_busy;
    logic        tx_done;
    logic        rx_busy;
    logic        rx_done;
    logic        rx_ferr;
    logic        rx_perr;
    logic [7:0]  rx_data;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    // ***************************************************************
    // apb decode
    // ***************************************************************
    // zero wait states keep the bus logic minimal
    wire sel_ctrl = hit(paddr, ufc_pkg::UFC_OFF_CTRL);
    wire sel_stat = hit(paddr, ufc_pkg::UFC_OFF_STAT);
    wire sel_mask = hit(paddr, ufc_pkg::UFC_OFF_MASK);
    wire sel_data = hit(paddr, ufc_pkg::UFC_OFF_DATA);
    wire sel_baud = hit(paddr, ufc_pkg::UFC_OFF_BAUD);
    wire mapped   = sel_ctrl | sel_stat | sel_mask | sel_data | sel_baud;
    wire access   = psel && penable;
    wire setup    = psel && !penable;
    wire wr       = access && pwrite && mapped;
    wire rd       = access && !pwrite && mapped;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // abort is a pulse only, never stored, so it reads zero
    wire abort = wr && sel_ctrl && pwdata[ufc_pkg::UFC_ABORT_BIT];

    // read data assembled in setup so it is stable through the access phase
    wire [31:0] rd_mux =
        sel_ctrl ? {25'h0, ctrl_reg} :
        sel_stat ? {20'h0, rx_full_reg, tx_full_reg, rx_busy, tx_busy, 4'h0, stat_reg} :
        sel_mask ? {28'h0, mask_reg} :
        sel_data ? {24'h0, rx_data} :
        sel_baud ? {16'h0, baud_reg} : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) prdata_reg <= 32'h0000_0000;
        else if (setup) prdata_reg <= rd_mux;
    end
    assign prdata = prdata_reg;

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    // control resets to low start, one high stop bit
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= ufc_pkg::UFC_CTRL_RST;
            mask_reg <= 4'h0;
            baud_reg <= ufc_pkg::UFC_BAUD_RST;
        end else if (wr) begin
            if (sel_ctrl) ctrl_reg <= pwdata[6:0];
            if (sel_mask) mask_reg <= pwdata[3:0];
            if (sel_baud) baud_reg <= pwdata[15:0];
        end
    end

    // ***************************************************************
    // oversample divider
    // ***************************************************************
    // one tick per baud_reg+1 clocks, sixteen ticks per bit
    wire tick = (div_reg >= baud_reg);
    always_ff @(posedge clk) begin
        if (rst || tick) div_reg <= 16'h0000;
        else div_reg <= div_reg + 16'h0001;
    end

    // ***************************************************************
    // pin synchronisers
    // ***************************************************************
    // three stages; a level counts once stages two and three agree
    wire [1:0] pin_in  = {cts_n, rxd};
    wire [1:0] agree   = ~(s2_reg ^ s3_reg);
    wire [1:0] pin_nxt = (agree & s2_reg) | (~agree & pin_reg);
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg  <= 2'h3;
            s2_reg  <= 2'h3;
            s3_reg  <= 2'h3;
            pin_reg <= 2'h3;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= pin_nxt;
        end
    end
    wire rxd_f = pin_reg[0];
    wire cts_f = pin_reg[1];

    // ***************************************************************
    // flow control and transmit holding
    // ***************************************************************
    // cts only gates the start of a frame, never one already on the line
    wire cts_ok = !ctrl_reg.handshake_enable || !cts_f;
    wire tx_go  = tx_full_reg && !tx_busy && cts_ok && !abort;
    wire tx_wr  = wr && sel_data && !tx_full_reg;  // writes while full are dropped
    wire rx_rd  = rd && sel_data;

    always_ff @(posedge clk) begin
        if (rst) tx_hold_reg <= 8'h00;
        else if (tx_wr) tx_hold_reg <= pwdata[7:0];
    end

    // abort empties both holding flags; the clear wins over new data in the same cycle
    always_ff @(posedge clk) begin
        if (rst || abort) begin
            tx_full_reg <= 1'b0;
            rx_full_reg <= 1'b0;
        end else begin
            tx_full_reg <= tx_wr || (tx_full_reg && !tx_go);
            rx_full_reg <= rx_done || (rx_full_reg && !rx_rd);
        end
    end

    // rts deasserted while a character waits unread; held active when off
    always_ff @(posedge clk) begin
        if (rst) rts_n_reg <= 1'b1;
        else rts_n_reg <= ctrl_reg.handshake_enable && rx_full_reg;
    end
    assign rts_n = rts_n_reg;

    // ***************************************************************
    // serial engines
    // ***************************************************************
    ufc_tx u_tx (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .abort (abort),
        .cfg   (ctrl_reg),
        .go    (tx_go),
        .data  (tx_hold_reg),
        .txd   (txd),
        .busy  (tx_busy),
        .done  (tx_done)
    );

    ufc_rx u_rx (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .abort (abort),
        .cfg   (ctrl_reg),
        .rxd   (rxd_f),
        .data  (rx_data),
        .busy  (rx_busy),
        .done  (rx_done),
        .ferr  (rx_ferr),
        .perr  (rx_perr)
    );

    // ***************************************************************
    // interrupt status
    // ***************************************************************
    // a read clears only the bits it returned at setup, so an event landing
    // between capture and access is not lost; a set in the clear cycle wins
    assign evt_set   = {rx_perr, rx_ferr, tx_done, rx_done};
    assign stat_next = evt_set | (stat_reg & ~((rd && sel_stat) ? prdata_reg[3:0] : 4'h0));
    always_ff @(posedge clk) begin
        if (rst) stat_reg <= 4'h0;
        else stat_reg <= stat_next;
    end
    assign irq = |(stat_reg & mask_reg);

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [7:0] tc_reg;
    always_ff @(posedge clk) begin
        if (rst || !tx_busy) tc_reg <= 8'h00;
        else if (tick) tc_reg <= tc_reg + 8'h01;
    end
    wire [7:0] want_tc = {ufc_pkg::UFC_TX_BASE + {3'h0, ctrl_reg.nine_bit_enable}
                        + {3'h0, ctrl_reg.stop_count_select}, 4'h0};

    AST_ABORT_IDLE: assert property (abort |=> !tx_busy && !rx_busy && !tx_full_reg)
        else $error("abort did not idle the unit");
    AST_ABORT_READ0: assert property (rd && sel_ctrl |-> prdata[7] == 1'b0)
        else $error("abort bit read back as one");
    AST_CTS_HOLD: assert property (ctrl_reg.handshake_enable && cts_f && !tx_busy
                                   |=> !tx_busy)
        else $error("frame started while cts inactive");
    // rts is registered, so it follows the enable and reset one clock late
    wire rts_free = !ctrl_reg.handshake_enable && !rst;
    wire mask_wr  = wr && sel_mask;
    AST_RTS_OFF: assert property ($past(rts_free) |-> !rts_n)
        else $error("rts driven with flow control off");
    AST_FRAME_LEN: assert property ($fell(tx_busy) && !$past(abort) |-> tc_reg == want_tc
                                    || $past(tc_reg) == want_tc)
        else $error("transmitted frame length wrong");
    AST_START_LVL: assert property ($rose(tx_busy) |-> txd == ctrl_reg.begin_bit_level)
        else $error("start bit level wrong");
    AST_STOP_LVL: assert property ($fell(tx_busy) && !$past(abort)
                                   |-> $past(txd) == ctrl_reg.end_bit_level)
        else $error("stop bit level wrong");
    AST_CTRL_RST: assert property ($past(rst) |-> ctrl_reg == ufc_pkg::UFC_CTRL_RST)
        else $error("control reset value wrong");
    AST_FERR_CAUSE: assert property (rx_ferr |-> $past(rxd_f) != ctrl_reg.end_bit_level)
        else $error("framing error without bad stop bit");
    AST_PERR_CAUSE: assert property (rx_perr |-> ctrl_reg.check_bit_enable
                                     && ctrl_reg.nine_bit_enable)
        else $error("parity error with checking off");
    AST_IRQ_STICKY: assert property (rx_done && mask_reg.rx_done |=> irq [*2]
                                     or ##1 ($past(mask_wr) || $past(mask_wr, 2)))
        else $error("interrupt not held");

    COV_TX_FRAME: cover property ($fell(tx_busy) && !$past(abort));
    COV_RX_NINE: cover property (rx_done && ctrl_reg.nine_bit_enable);
    COV_ABORT_BUSY: cover property (abort && (tx_busy || rx_busy));
    COV_TWO_STOP: cover property (rx_ferr && ctrl_reg.stop_count_select);

endmodule : ufc_top

//--- ufc_pkg.sv
// shared constants and types of the uart frame control block
// assumes a 32-bit apb slave with byte addresses and one clock
package ufc_pkg;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [11:0] UFC_OFF_CTRL = 12'h0C4;
    localparam logic [11:0] UFC_OFF_STAT = 12'h0C8;
    localparam logic [11:0] UFC_OFF_MASK = 12'h0CC;
    localparam logic [11:0] UFC_OFF_DATA = 12'h0D0;
    localparam logic [11:0] UFC_OFF_BAUD = 12'h0D4;

    // ***************************************************************
    // fields and reset values
    // ***************************************************************
    localparam int          UFC_ABORT_BIT = 7;
    localparam logic [6:0]  UFC_CTRL_RST  = 7'h02;   // one high stop bit, rest zero
    localparam logic [15:0] UFC_BAUD_RST  = 16'h0014;
    localparam int          UFC_BUSY_TX   = 8;
    localparam int          UFC_BUSY_RX   = 9;
    localparam int          UFC_FULL_TX   = 10;
    localparam int          UFC_FULL_RX   = 11;
    localparam logic [3:0]  UFC_OS_LAST   = 4'hF;    // 16 ticks per bit
    localparam logic [3:0]  UFC_OS_MID    = 4'h7;
    localparam logic [3:0]  UFC_TX_BASE   = 4'hA;    // start, 8 data, 1 stop
    localparam logic [3:0]  UFC_RX_DATA   = 4'h8;

    // control fields in register bit order 6..0
    typedef struct packed {
        logic handshake_enable;
        logic ninth_bit_value;
        logic nine_bit_enable;
        logic check_bit_enable;
        logic stop_count_select;
        logic end_bit_level;
        logic begin_bit_level;
    } ufc_cfg_s;

    // sticky event bits
    typedef struct packed {
        logic parity_err;
        logic frame_err;
        logic tx_done;
        logic rx_done;
    } ufc_evt_s;

    typedef enum logic {
        UFC_TX_IDLE = 1'b0,
        UFC_TX_SEND = 1'b1
    } ufc_tx_state_e;

    typedef enum logic [1:0] {
        UFC_RX_IDLE  = 2'b00,
        UFC_RX_START = 2'b01,
        UFC_RX_BITS  = 2'b10
    } ufc_rx_state_e;

endpackage : ufc_pkg

//--- ufc_tx.sv
// transmitter: serialises one character per go pulse
// assumes a 16x oversample tick enable and a config that is steady per frame
`timescale 1ns/1ps
module ufc_tx (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             abort,
    input  ufc_pkg::ufc_cfg_s     cfg,
    input  wire logic             go,
    input  wire logic [7:0]       data,
    output logic                  txd,
    output logic                  busy,
    output logic                  done
);
    ufc_pkg::ufc_tx_state_e state_reg;
    logic [10:0] sh_reg;
    logic [3:0]  left_reg;
    logic [3:0]  sub_reg;
    logic        txd_reg;
    logic        done_reg;

    // ***************************************************************
    // frame assembly
    // ***************************************************************
    // ninth bit is parity over the data or the literal value
    wire        ninth = cfg.check_bit_enable ? (^data ^ cfg.ninth_bit_value)
                                             : cfg.ninth_bit_value;
    wire        idle_lvl = ~cfg.begin_bit_level;
    // data lsb first, ninth after data, then stops; 8-bit frames skip ninth
    wire [10:0] frame = cfg.nine_bit_enable
                      ? {cfg.end_bit_level, cfg.end_bit_level, ninth, data}
                      : {1'b1, cfg.end_bit_level, cfg.end_bit_level, data};
    // bits after the start bit, minus one
    wire [3:0]  nbits = UFC_LEN(cfg);
    wire        bit_end = tick && (sub_reg == ufc_pkg::UFC_OS_LAST);

    function automatic logic [3:0] UFC_LEN(input ufc_pkg::ufc_cfg_s c);
        UFC_LEN = ufc_pkg::UFC_TX_BASE - 4'h1 + {3'h0, c.nine_bit_enable}
                + {3'h0, c.stop_count_select} - 4'h1;
    endfunction : UFC_LEN

    // shift engine; abort drops the frame at once
    always_ff @(posedge clk) begin
        done_reg <= 1'b0;
        if (rst || abort) begin
            state_reg <= ufc_pkg::UFC_TX_IDLE;
            txd_reg   <= rst ? 1'b1 : idle_lvl;
            sh_reg    <= 11'h000;
            left_reg  <= 4'h0;
            sub_reg   <= 4'h0;
        end else begin
            unique case (state_reg)
                ufc_pkg::UFC_TX_IDLE: begin
                    txd_reg <= idle_lvl;
                    if (go) begin
                        state_reg <= ufc_pkg::UFC_TX_SEND;
                        txd_reg   <= cfg.begin_bit_level;
                        sh_reg    <= frame;
                        left_reg  <= nbits + 4'h1;
                        sub_reg   <= 4'h0;
                    end
                end
                ufc_pkg::UFC_TX_SEND: begin
                    if (tick) sub_reg <= sub_reg + 4'h1;
                    if (bit_end && left_reg == 4'h0) begin
                        state_reg <= ufc_pkg::UFC_TX_IDLE;
                        txd_reg   <= idle_lvl;
                        done_reg  <= 1'b1;
                    end else if (bit_end) begin
                        txd_reg  <= sh_reg[0];
                        sh_reg   <= {1'b0, sh_reg[10:1]};
                        left_reg <= left_reg - 4'h1;
                    end
                end
            endcase
        end
    end

    assign txd  = txd_reg;
    assign busy = (state_reg == ufc_pkg::UFC_TX_SEND);
    assign done = done_reg;

endmodule : ufc_tx

//--- ufc_rx.sv
// receiver: samples mid-bit, reports character, framing and parity faults
// assumes a filtered line input and a 16x oversample tick enable
`timescale 1ns/1ps
module ufc_rx (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             abort,
    input  ufc_pkg::ufc_cfg_s     cfg,
    input  wire logic             rxd,
    output logic [7:0]            data,
    output logic                  busy,
    output logic                  done,
    output logic                  ferr,
    output logic                  perr
);
    ufc_pkg::ufc_rx_state_e state_reg;
    logic [8:0] sh_reg;
    logic [3:0] idx_reg;
    logic [3:0] sub_reg;
    logic [7:0] data_reg;
    logic       done_reg;
    logic       ferr_reg;
    logic       perr_reg;

    // ***************************************************************
    // sampling
    // ***************************************************************
    wire [3:0] ndata  = ufc_pkg::UFC_RX_DATA + {3'h0, cfg.nine_bit_enable};
    wire       mid    = tick && (sub_reg == ufc_pkg::UFC_OS_MID);
    wire       sample = tick && (sub_reg == ufc_pkg::UFC_OS_LAST);
    wire       bad_stop = (rxd != cfg.end_bit_level);
    // odd count of ones over data and ninth must equal the sense bit
    wire       bad_par = cfg.nine_bit_enable && cfg.check_bit_enable
                      && ((^sh_reg) != cfg.ninth_bit_value);

    // start is a departure from the idle level abort idles
    always_ff @(posedge clk) begin
        done_reg <= 1'b0;
        ferr_reg <= 1'b0;
        perr_reg <= 1'b0;
        if (rst || abort) begin
            state_reg <= ufc_pkg::UFC_RX_IDLE;
            sub_reg   <= 4'h0;
            idx_reg   <= 4'h0;
            sh_reg    <= 9'h000;
            data_reg  <= rst ? 8'h00 : data_reg;
        end else begin
            unique case (state_reg)
                ufc_pkg::UFC_RX_IDLE: begin
                    sub_reg <= 4'h0;
                    idx_reg <= 4'h0;
                    if (rxd == cfg.begin_bit_level) state_reg <= ufc_pkg::UFC_RX_START;
                end
                ufc_pkg::UFC_RX_START: begin
                    if (tick) sub_reg <= sub_reg + 4'h1;
                    if (mid) begin
                        sub_reg   <= 4'h0;
                        // a glitch shorter than half a bit is dropped
                        state_reg <= (rxd == cfg.begin_bit_level) ? ufc_pkg::UFC_RX_BITS
                                                                  : ufc_pkg::UFC_RX_IDLE;
                    end
                end
                ufc_pkg::UFC_RX_BITS: begin
                    if (tick) sub_reg <= sub_reg + 4'h1;
                    if (sample) begin
                        idx_reg <= idx_reg + 4'h1;
                        if (idx_reg < ndata) begin
                            sh_reg[idx_reg] <= rxd;
                        end else if (idx_reg == ndata) begin
                            data_reg <= sh_reg[7:0];
                            done_reg <= 1'b1;
                            ferr_reg <= bad_stop;
                            perr_reg <= bad_par;
                            if (!cfg.stop_count_select) state_reg <= ufc_pkg::UFC_RX_IDLE;
                        end else begin
                            // second stop is checked one bit later
                            ferr_reg  <= bad_stop;
                            state_reg <= ufc_pkg::UFC_RX_IDLE;
                        end
                    end
                end
                default: state_reg <= ufc_pkg::UFC_RX_IDLE;
            endcase
        end
    end

    assign data = data_reg;
    assign busy = (state_reg != ufc_pkg::UFC_RX_IDLE);
    assign done = done_reg;
    assign ferr = ferr_reg;
    assign perr = perr_reg;

endmodule : ufc_rx

//--- ufc_peer.sv
// remote serial partner: sends frames on rxd, captures txd, drives cts_n
// assumes one oversample tick per clock, so a bit lasts 16 clocks
`timescale 1ns/1ps
module ufc_peer (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd = 1'b1,
    output logic      cts_n = 1'b0
);
    // lsb first, then back to the idle level; caller sets the stop count
    task send(input logic [11:0] f, input int n, input logic idl);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (16) @(posedge clk);
        end
        rxd <= idl;
    endtask : send
    // mid-bit samples; twelve taken, caller masks to the frame length
    task grab(input logic st, output logic [11:0] f);
        while (txd !== st) @(posedge clk);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            f[i] = txd;
            repeat (16) @(posedge clk);
        end
    endtask : grab
    task cts(input logic v);
        cts_n <= v;
    endtask : cts
endmodule : ufc_peer

//--- uart_frame_format_control_tb.sv
// testbench: apb registers, frames both ways, abort, flow control, irq
// assumes ufc_top and the partner ufc_peer on one 40 mhz clock
`timescale 1ns/1ps
module uart_frame_format_control_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, r, e;
    logic        pready, pslverr, rxd, txd, cts_n, rts_n, irq, se, pe, fe;
    logic [11:0] f, g;
    logic [6:0]  c;
    logic [7:0]  d;
    logic [3:0]  m;
    int          n_fail = 0;
    int          comparisons = 0;
    always #12.5 clk = ~clk;
    ufc_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
    ufc_peer peer (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] q);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // a line flip of idle level may start a bogus frame, so abort after it
    task cfg(input logic [6:0] v);
        logic [31:0] t;
        apb(1'b1, ufc_pkg::UFC_OFF_CTRL, {25'h0, v}, t);
        peer.send(12'h0, 0, ~v[0]);
        repeat (6) @(posedge clk);
        apb(1'b1, ufc_pkg::UFC_OFF_CTRL, {24'h0, 1'b1, v}, t);
        apb(1'b0, ufc_pkg::UFC_OFF_STAT, 32'h0, t);
    endtask : cfg
    function automatic int len(input logic [6:0] v);
        return 10 + v[4] + v[2];
    endfunction : len
    // expected frame, start bit in bit 0
    function automatic logic [11:0] frm(input logic [6:0] v, input logic [7:0] b);
        logic [11:0] x;
        x = {3'h0, b, v[0]};
        if (v[4]) x[9] = v[3] ? (^b ^ v[5]) : v[5];
        x[9 + v[4]] = v[1];
        if (v[2]) x[10 + v[4]] = v[1];
        return x;
    endfunction : frm
    // watchdog, far beyond the planned run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test;
    end
    // main sequence
    initial begin
        void'($urandom(11));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, ufc_pkg::UFC_OFF_CTRL, 32'h0, r);
        chk("ctrl reset", r, 32'h02);
        apb(1'b0, ufc_pkg::UFC_OFF_BAUD, 32'h0, r);
        chk("baud reset", r, {16'h0, ufc_pkg::UFC_BAUD_RST});
        apb(1'b1, ufc_pkg::UFC_OFF_BAUD, 32'h0, r);
        apb(1'b0, 12'h0F0, 32'h0, r);
        chk("unmapped err", se, 32'h1);
        chk("unmapped data", r, 32'h0);
        chk("unmapped ready", pready, 32'h1);
        $display("test reset done");
        for (int k = 0; k < 12; k++) begin
            c = (k == 0) ? 7'h3F : (k == 1) ? 7'h1A : 7'($urandom) & 7'h3F;
            d = 8'($urandom);
            m = 4'($urandom);
            pe = 1'($urandom);
            fe = 1'($urandom);
            cfg(c);
            apb(1'b1, ufc_pkg::UFC_OFF_MASK, {28'h0, m}, r);
            apb(1'b1, ufc_pkg::UFC_OFF_DATA, {24'h0, d}, r);
            f = frm(c, d);
            if (c[4]) f[9] = f[9] ^ pe;
            f[9 + c[4]] = f[9 + c[4]] ^ fe;
            fork
                peer.grab(c[0], g);
                peer.send(f, len(c), ~c[0]);
            join
            repeat (30) @(posedge clk);
            chk("tx frame", g & (12'hFFF >> (12 - len(c))), frm(c, d));
            e = {20'h0, 4'h8, 4'h0, pe & c[4] & c[3], fe, 2'h3};
            chk("irq level", irq, |(e[3:0] & m));
            apb(1'b0, ufc_pkg::UFC_OFF_STAT, 32'h0, r);
            chk("status", r, e);
            apb(1'b0, ufc_pkg::UFC_OFF_DATA, 32'h0, r);
            chk("rx data", r, {24'h0, d});
            chk("irq cleared", irq, 32'h0);
        end
        $display("test frames done");
        cfg(7'h02);
        apb(1'b1, ufc_pkg::UFC_OFF_DATA, 32'h55, r);
        repeat (40) @(posedge clk);
        apb(1'b1, ufc_pkg::UFC_OFF_CTRL, 32'h82, r);
        repeat (2) @(posedge clk);
        chk("abort idle", txd, 32'h1);
        apb(1'b0, ufc_pkg::UFC_OFF_STAT, 32'h0, r);
        chk("abort busy", r[10:8], 32'h0);
        apb(1'b0, ufc_pkg::UFC_OFF_CTRL, 32'h0, r);
        chk("abort reads", r, 32'h02);
        $display("test abort done");
        cfg(7'h42);
        peer.cts(1'b1);
        // the pin filter needs a few clocks before cts can hold a frame back
        repeat (6) @(posedge clk);
        apb(1'b1, ufc_pkg::UFC_OFF_DATA, 32'hA5, r);
        peer.send(frm(7'h42, 8'h3C), 10, 1'b1);
        repeat (30) @(posedge clk);
        chk("cts holds", txd, 32'h1);
        chk("rts raised", rts_n, 32'h1);
        apb(1'b0, ufc_pkg::UFC_OFF_STAT, 32'h0, r);
        chk("cts waits", r, 32'hC01);
        peer.cts(1'b0);
        peer.grab(1'b0, g);
        chk("cts frame", g & 12'h3FF, frm(7'h42, 8'hA5));
        apb(1'b0, ufc_pkg::UFC_OFF_DATA, 32'h0, r);
        chk("cts rx data", r, 32'h3C);
        repeat (2) @(posedge clk);
        chk("rts freed", rts_n, 32'h0);
        $display("test flow done");
        end_of_test;
    end
endmodule : uart_frame_format_control_tb
